/* hdl/sense_monitor_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SENSE_MONITOR_DEFS_SVH
`define SENSE_MONITOR_DEFS_SVH

`define REG_CTRL        8'h00
`define REG_CFG         8'h04
`define REG_RATE        8'h08
`define REG_UPDATE      8'h0c
`define REG_TEMP_HIGH   8'h10
`define REG_TEMP_LOW    8'h14
`define REG_SUPPLY_HIGH 8'h18
`define REG_SUPPLY_LOW  8'h1c
`define REG_BATT_HIGH   8'h20
`define REG_BATT_LOW    8'h24
`define REG_MIN_HIGH    8'h28
`define REG_MIN_LOW     8'h2c
`define REG_STATUS      8'h30

`define CTRL_GLOBAL_EN  0
`define CTRL_SENSE_EN   1
`define CTRL_DITHER     3
`define CTRL_DCBLK      4
`define CTRL_PCM_TX     6
`define CTRL_RESET      32'h0000_0000

`define CFG_SUPPLY_EN   0
`define CFG_BATT_EN     1
`define CFG_MANUAL      2
`define CFG_FILT_EN     5
`define CFG_COEFF       8
`define CFG_COEFF_W     4
`define CFG_RESET       32'h0000_0000

`define RATE_FIELD_W    8
`define RATE_RESET      32'h0000_0000

`define CH_TEMP         2'd0
`define CH_SUPPLY       2'd1
`define CH_BATT         2'd2

`define MIN_RESET       9'h1ff
`define DCBLK_SHIFT     10
`define LFSR_SEED       16'hace1
`define LFSR_TAPS       16'hb400
`define PCM_FRAME_BITS  48
`define FRAC_ZERO       8'h00

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define CLK_PERIOD_NS   8
`define MEAS_TICK_NS    1000

`endif

/* hdl/sense_monitor_pkg.sv */
// shared types of the sense and measurement control block
package sense_monitor_pkg;
	typedef logic [8:0] meas_t;
	typedef logic signed [15:0] sense_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT} seq_state_e;
endpackage

/* hdl/meas_chan_if.sv */
// per-channel bundle between the sequencer and one measurement channel
`timescale 1ns/1ns
interface meas_chan_if;
	logic       manual;
	logic       updateStrobe;
	logic       filterEnable;
	logic [3:0] coeff;
	logic [8:0] sample;
	logic       sampleValid;
	logic       minClear;
	logic [8:0] filtered;
	logic       filteredValid;
	logic [8:0] readback;
	logic [8:0] minimum;
	modport ctrl (output manual, updateStrobe, filterEnable, coeff, sample, sampleValid,
		minClear, input filtered, filteredValid, readback, minimum);
	modport chan (input manual, updateStrobe, filterEnable, coeff, sample, sampleValid,
		minClear, output filtered, filteredValid, readback, minimum);
endinterface

/* hdl/meas_channel.sv */
// one measurement channel: lowpass filter, readback holding, minimum tracker
`timescale 1ns/1ns
`include "sense_monitor_defs.svh"
module meas_channel
	import sense_monitor_pkg::*;
(
	input wire logic  mclk,
	input wire logic  reset,
	meas_chan_if.chan port
);
	logic        [16:0] acc;
	logic signed [17:0] delta;

	always_comb begin
		delta = $signed({1'b0, port.sample, `FRAC_ZERO}) - $signed({1'b0, acc});
	end

	assign port.filtered = acc[16:8];

	// one-pole lowpass, bandwidth set by the shift and the channel rate
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			acc <= '0;
			port.filteredValid <= 1'b0;
		end else begin
			port.filteredValid <= port.sampleValid;
			if (port.sampleValid) begin
				if (port.filterEnable) begin
					acc <= acc + 17'(delta >>> port.coeff);
				end else begin
					acc <= {port.sample, `FRAC_ZERO};
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port.readback <= '0;
		end else if (!port.manual && port.filteredValid) begin
			port.readback <= acc[16:8];
		end else if (port.manual && port.updateStrobe) begin
			port.readback <= acc[16:8];
		end
	end

	// reload on clear also covers a result landing in the same cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port.minimum <= `MIN_RESET;
		end else if (port.minClear || (port.filteredValid && acc[16:8] < port.minimum)) begin
			port.minimum <= acc[16:8];
		end
	end
endmodule

/* hdl/sense_and_monitor_adc_ctrl.sv */
// sense path, measurement sequencer, pcm output and axi4-lite registers
// How it works
// - dither bit adds one lsb when enabled
// - separate optional highpass dc blocks per path
// - sense samples leave on pcm serial output
// - one 9-bit converter, three measurement channels
// - enabled channels converted continuously in turn
// - per-channel rate and optional lowpass filter
// - temperature runs whenever global enable set
// - temperature result feeds protection, foldback, readback
// - auto mode refreshes readback each conversion
// - manual mode refreshes only on update write
// - temperature readback and stream are 9 bits
// - split readback may mix two conversions
// - temperature lowpass only when its enable set
// - supply channel needs its enable and global
// - supply result to readback and headroom tracker
// - lowest supply value kept in high/low pair
// - low read clears and reloads lowest value
// - 16-bit sense paths with own enables
// - pcm output only with transmit enable
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "sense_monitor_defs.svh"
module sense_and_monitor_adc_ctrl
	import sense_monitor_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	input  wire logic        senseValid,
	input  wire logic [15:0] currentRaw,
	input  wire logic [15:0] voltageRaw,
	output var  logic        measStart,
	output var  logic [1:0]  measChannel,
	input  wire logic        measDone,
	input  wire logic [8:0]  measRaw,
	output var  logic [8:0]  tempResult,
	output var  logic        tempResultValid,
	output var  logic [8:0]  supplyResult,
	output var  logic        supplyResultValid,
	input  wire logic        pcmBclk,
	input  wire logic        pcmLrclk,
	output var  logic        pcmDout,
	output var  logic        pcmDoutEnable
);
	localparam int TICK_CYCLES = (`MEAS_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	logic [31:0] ctrlReg;
	logic [31:0] cfgReg;
	logic [31:0] rateReg;
	logic [2:0]  updPulse;
	logic        minReadPulse;
	logic        awHeld;
	logic        wHeld;
	logic [7:0]  awAddrHeld;
	logic [31:0] wDataHeld;
	logic [3:0]  wStrbHeld;
	logic        doWrite;
	logic        next_awHeld;
	logic        next_wHeld;
	logic        next_bvalid;
	logic        next_rvalid;
	logic [2:0]  chanEnabled;
	logic [2:0]  dueVec;
	logic [2:0]  grant;
	logic [7:0]  tickCount;
	logic        tick;
	logic [1:0]  lastChannel;
	logic [1:0]  pick;
	logic        pickValid;
	seq_state_e  seqState;
	logic [15:0] lfsr;
	logic [1:0]  bclkSync;
	logic [1:0]  lrSync;
	logic        bclkPrev;
	logic        lrPrev;
	logic [`PCM_FRAME_BITS-1:0] frameShift;

	meas_chan_if chan[3] ();

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic writable(input logic [7:0] a);
		return a == `REG_CTRL || a == `REG_CFG || a == `REG_RATE || a == `REG_UPDATE;
	endfunction

	// write channel: address and data taken in either order
	assign doWrite = awHeld && wHeld && !bvalid;

	always_comb begin
		next_awHeld = (awvalid && awready) ? 1'b1 : (doWrite ? 1'b0 : awHeld);
		next_wHeld = (wvalid && wready) ? 1'b1 : (doWrite ? 1'b0 : wHeld);
		next_bvalid = doWrite ? 1'b1 : ((bvalid && bready) ? 1'b0 : bvalid);
		next_rvalid = (arvalid && arready) ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			awAddrHeld <= '0;
			wDataHeld <= '0;
			wStrbHeld <= '0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			bvalid <= next_bvalid;
			awready <= !next_awHeld && !next_bvalid;
			wready <= !next_wHeld && !next_bvalid;
			if (awvalid && awready) begin
				awAddrHeld <= awaddr;
			end
			if (wvalid && wready) begin
				wDataHeld <= wdata;
				wStrbHeld <= wstrb;
			end
			if (doWrite) begin
				bresp <= writable(awAddrHeld) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrlReg <= `CTRL_RESET;
			cfgReg <= `CFG_RESET;
			rateReg <= `RATE_RESET;
			updPulse <= '0;
		end else begin
			updPulse <= '0;
			if (doWrite) begin
				case (awAddrHeld)
					`REG_CTRL: ctrlReg <= mergeBytes(ctrlReg, wDataHeld, wStrbHeld);
					`REG_CFG: cfgReg <= mergeBytes(cfgReg, wDataHeld, wStrbHeld);
					`REG_RATE: rateReg <= mergeBytes(rateReg, wDataHeld, wStrbHeld);
					`REG_UPDATE: updPulse <= wStrbHeld[0] ? wDataHeld[2:0] : 3'h0;
					default: updPulse <= '0;
				endcase
			end
		end
	end

	// high part is value[8:1], low part value[0]; read separately
	function automatic logic [31:0] readMux(input logic [7:0] a);
		case (a)
			`REG_CTRL: return ctrlReg;
			`REG_CFG: return cfgReg;
			`REG_RATE: return rateReg;
			`REG_TEMP_HIGH: return {24'h0, chan[0].readback[8:1]};
			`REG_TEMP_LOW: return {31'h0, chan[0].readback[0]};
			`REG_SUPPLY_HIGH: return {24'h0, chan[1].readback[8:1]};
			`REG_SUPPLY_LOW: return {31'h0, chan[1].readback[0]};
			`REG_BATT_HIGH: return {24'h0, chan[2].readback[8:1]};
			`REG_BATT_LOW: return {31'h0, chan[2].readback[0]};
			`REG_MIN_HIGH: return {24'h0, chan[1].minimum[8:1]};
			`REG_MIN_LOW: return {31'h0, chan[1].minimum[0]};
			`REG_STATUS: return {28'h0, seqState == SEQ_WAIT, dueVec};
			default: return 32'h0;
		endcase
	endfunction

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RESP_OKAY;
			minReadPulse <= 1'b0;
		end else begin
			rvalid <= next_rvalid;
			arready <= !next_rvalid;
			minReadPulse <= arvalid && arready && araddr == `REG_MIN_LOW;
			if (arvalid && arready) begin
				rdata <= readMux(araddr);
				rresp <= (readMux(araddr) == 32'h0 && araddr > `REG_STATUS) ?
					`RESP_SLVERR : `RESP_OKAY;
			end
		end
	end

	// channel enables and per-channel rate counters
	assign chanEnabled[0] = ctrlReg[`CTRL_GLOBAL_EN];
	assign chanEnabled[1] = ctrlReg[`CTRL_GLOBAL_EN] && cfgReg[`CFG_SUPPLY_EN];
	assign chanEnabled[2] = ctrlReg[`CTRL_GLOBAL_EN] && cfgReg[`CFG_BATT_EN];
	assign tick = tickCount == 8'(TICK_CYCLES - 1);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tickCount <= '0;
		end else begin
			tickCount <= tick ? 8'h00 : tickCount + 8'h01;
		end
	end

	for (genvar i = 0; i < 3; i++) begin : rateGen
		logic [7:0] rateCount;
		logic       due;
		assign dueVec[i] = due;
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				rateCount <= '0;
				due <= 1'b0;
			end else if (!chanEnabled[i]) begin
				rateCount <= '0;
				due <= 1'b0;
			end else begin
				if (grant[i]) begin
					due <= 1'b0;
				end
				if (tick) begin
					if (rateCount >= rateReg[`RATE_FIELD_W*i +: `RATE_FIELD_W]) begin
						rateCount <= '0;
						due <= 1'b1;
					end else begin
						rateCount <= rateCount + 8'h01;
					end
				end
			end
		end
		assign chan[i].manual = cfgReg[`CFG_MANUAL + i];
		assign chan[i].filterEnable = cfgReg[`CFG_FILT_EN + i];
		assign chan[i].coeff = cfgReg[`CFG_COEFF + `CFG_COEFF_W*i +: `CFG_COEFF_W];
		assign chan[i].updateStrobe = updPulse[i];
		assign chan[i].minClear = (i == 1) && minReadPulse;
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				chan[i].sampleValid <= 1'b0;
				chan[i].sample <= '0;
			end else begin
				chan[i].sampleValid <= seqState == SEQ_WAIT && measDone && measChannel == 2'(i);
				if (seqState == SEQ_WAIT && measDone) begin
					chan[i].sample <= measRaw;
				end
			end
		end
		meas_channel chanUnit (
			.mclk  (mclk),
			.reset (reset),
			.port  (chan[i])
		);
	end

	// round robin search from the channel after the last one served
	always_comb begin
		logic [1:0] idx;
		idx = lastChannel;
		pick = lastChannel;
		pickValid = 1'b0;
		for (int k = 0; k < 3; k++) begin
			idx = (idx == `CH_BATT) ? `CH_TEMP : idx + 2'd1;
			if (!pickValid && dueVec[idx] && chanEnabled[idx]) begin
				pick = idx;
				pickValid = 1'b1;
			end
		end
	end

	assign grant = (seqState == SEQ_IDLE && pickValid) ? 3'(3'h1 << pick) : 3'h0;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			seqState <= SEQ_IDLE;
			measStart <= 1'b0;
			measChannel <= `CH_TEMP;
			lastChannel <= `CH_BATT;
		end else begin
			measStart <= 1'b0;
			case (seqState)
				SEQ_IDLE: begin
					if (pickValid) begin
						measChannel <= pick;
						measStart <= 1'b1;
						seqState <= SEQ_WAIT;
					end
				end
				SEQ_WAIT: begin
					if (measDone || !ctrlReg[`CTRL_GLOBAL_EN]) begin
						lastChannel <= measChannel;
						seqState <= SEQ_IDLE;
					end
				end
				default: seqState <= SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tempResult <= '0;
			tempResultValid <= 1'b0;
			supplyResult <= '0;
			supplyResultValid <= 1'b0;
		end else begin
			tempResultValid <= chan[0].filteredValid;
			supplyResultValid <= chan[1].filteredValid;
			if (chan[0].filteredValid) begin
				tempResult <= chan[0].filtered;
			end
			if (chan[1].filteredValid) begin
				supplyResult <= chan[1].filtered;
			end
		end
	end

	// sense paths: optional dc block, then optional dither
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lfsr <= `LFSR_SEED;
		end else if (senseValid) begin
			lfsr <= lfsr[0] ? ((lfsr >> 1) ^ `LFSR_TAPS) : (lfsr >> 1);
		end
	end

	for (genvar i = 0; i < 2; i++) begin : senseGen
		sense_t             raw;
		sense_t             xPrev;
		sense_t             yPrev;
		sense_t             sat;
		sense_t             filt;
		sense_t             outSample;
		logic signed [17:0] hp;
		logic               enable;
		assign raw = $signed((i == 0) ? currentRaw : voltageRaw);
		assign enable = ctrlReg[`CTRL_GLOBAL_EN] && ctrlReg[`CTRL_SENSE_EN + i];
		always_comb begin
			hp = 18'(raw) - 18'(xPrev) + 18'(yPrev) - 18'(yPrev >>> `DCBLK_SHIFT);
			if (hp[17:15] != 3'b000 && hp[17:15] != 3'b111) begin
				sat = hp[17] ? 16'sh8000 : 16'sh7fff;
			end else begin
				sat = hp[15:0];
			end
			filt = ctrlReg[`CTRL_DCBLK + i] ? sat : raw;
		end
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				xPrev <= '0;
				yPrev <= '0;
				outSample <= '0;
			end else if (senseValid) begin
				if (!enable) begin
					xPrev <= '0;
					yPrev <= '0;
					outSample <= '0;
				end else begin
					xPrev <= raw;
					yPrev <= sat;
					if (ctrlReg[`CTRL_DITHER] && lfsr[i] && filt != 16'sh7fff) begin
						outSample <= filt + 16'sh0001;
					end else begin
						outSample <= filt;
					end
				end
			end
		end
	end

	// pcm transmit: frame on lrclk rise, next bit on each bclk fall
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bclkSync <= '0;
			lrSync <= '0;
			bclkPrev <= 1'b0;
			lrPrev <= 1'b0;
		end else begin
			bclkSync <= {bclkSync[0], pcmBclk};
			lrSync <= {lrSync[0], pcmLrclk};
			bclkPrev <= bclkSync[1];
			lrPrev <= lrSync[1];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			frameShift <= '0;
			pcmDout <= 1'b0;
			pcmDoutEnable <= 1'b0;
		end else begin
			pcmDoutEnable <= ctrlReg[`CTRL_PCM_TX];
			if (lrSync[1] && !lrPrev) begin
				frameShift <= {senseGen[0].outSample[14:0], senseGen[1].outSample,
					tempResult, 8'h00};
				pcmDout <= ctrlReg[`CTRL_PCM_TX] && senseGen[0].outSample[15];
			end else if (!bclkSync[1] && bclkPrev) begin
				frameShift <= {frameShift[`PCM_FRAME_BITS-2:0], 1'b0};
				pcmDout <= ctrlReg[`CTRL_PCM_TX] && frameShift[`PCM_FRAME_BITS-1];
			end else if (!ctrlReg[`CTRL_PCM_TX]) begin
				pcmDout <= 1'b0;
			end
		end
	end

	sequence convIssue;
		measStart ##1 (seqState == SEQ_WAIT && !measStart);
	endsequence

	chk_dither_bypass: assert property (senseValid && senseGen[0].enable &&
		!ctrlReg[`CTRL_DITHER] && !ctrlReg[`CTRL_DCBLK]
		|=> senseGen[0].outSample == $signed($past(currentRaw)))
		else $error("sense sample changed with dither and dc block off");
	chk_dc_settle: assert property (senseValid && senseGen[0].enable &&
		ctrlReg[`CTRL_DCBLK] && !ctrlReg[`CTRL_DITHER]
		&& senseGen[0].raw == senseGen[0].xPrev && senseGen[0].yPrev == 16'sh0000
		|=> senseGen[0].outSample == 16'sh0000)
		else $error("dc block passed a constant input");
	chk_sense_off: assert property (senseValid && !senseGen[1].enable
		|=> senseGen[1].outSample == 16'sh0000)
		else $error("disabled voltage path produced data");
	chk_pcm_gate: assert property (!ctrlReg[`CTRL_PCM_TX] |=> !pcmDout && !pcmDoutEnable)
		else $error("pcm output active without transmit enable");
	chk_seq_issue: assert property (measStart && ctrlReg[`CTRL_GLOBAL_EN] |-> convIssue)
		else $error("conversion start not followed by wait");
	chk_supply_gate: assert property (measStart && measChannel == `CH_SUPPLY
		|-> $past(chanEnabled[1]))
		else $error("supply converted while disabled");
	chk_temp_gate: assert property (measStart |-> $past(ctrlReg[`CTRL_GLOBAL_EN]))
		else $error("conversion started without global enable");
	chk_temp_out: assert property (chan[0].filteredValid
		|=> tempResultValid && tempResult == $past(chan[0].filtered))
		else $error("temperature result not forwarded");
	chk_temp_auto: assert property (chan[0].filteredValid && !chan[0].manual
		|=> chan[0].readback == $past(chan[0].filtered))
		else $error("auto readback not refreshed");
	chk_temp_manual: assert property (chan[0].manual && !chan[0].updateStrobe
		|=> $stable(chan[0].readback))
		else $error("manual readback changed without update");
	chk_min_reload: assert property (chan[1].minClear
		|=> chan[1].minimum == $past(chan[1].filtered))
		else $error("minimum not reloaded after low read");
	chk_min_track: assert property (chan[1].filteredValid
		|=> chan[1].minimum <= $past(chan[1].filtered))
		else $error("minimum above latest supply result");
endmodule

/* verif/meas_adc_model.sv */
// behavioural measurement converter answering start pulses
`timescale 1ns/1ns
module meas_adc_model (
	input  wire logic       mclk,
	input  wire logic       slow,
	input  wire logic       measStart,
	input  wire logic [1:0] measChannel,
	input  wire logic [8:0] tempVal,
	input  wire logic [8:0] supplyVal,
	output var  logic       measDone,
	output var  logic [8:0] measRaw
);
	int         cnt;
	logic [1:0] ch;
	logic [8:0] last;
	initial begin
		measDone = 1'b0;
		measRaw = 9'h000;
		cnt = 0;
		last = 9'h000;
	end
	always @(posedge mclk) begin
		measDone <= 1'b0;
		// bus driven with the inverse of the last result between results
		measRaw <= ~last;
		if (measStart) begin
			cnt <= slow ? 40 : 3;
			ch <= measChannel;
		end else if (cnt == 1) begin
			measDone <= 1'b1;
			measRaw <= (ch == 2'd0) ? tempVal : (ch == 2'd1) ? supplyVal : 9'h0aa;
			last <= (ch == 2'd0) ? tempVal : (ch == 2'd1) ? supplyVal : 9'h0aa;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the sense and measurement control block
`timescale 1ns/1ns
`include "sense_monitor_defs.svh"
module tb_top;
	logic        mclk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, senseValid, measStart, measDone;
	logic        tempResultValid, supplyResultValid, pcmBclk, pcmLrclk, pcmDout;
	logic        pcmDoutEnable, slow;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, measChannel;
	logic [15:0] currentRaw, voltageRaw;
	logic [8:0]  measRaw, tempResult, supplyResult, tempVal, supplyVal;
	int          mismatches, checkCount, starts;

	sense_and_monitor_adc_ctrl uut (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .senseValid, .currentRaw, .voltageRaw,
		.measStart, .measChannel, .measDone, .measRaw, .tempResult, .tempResultValid,
		.supplyResult, .supplyResultValid, .pcmBclk, .pcmLrclk, .pcmDout, .pcmDoutEnable);
	meas_adc_model model (.mclk, .slow, .measStart, .measChannel, .tempVal, .supplyVal,
		.measDone, .measRaw);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) if (measStart === 1'b1) starts++;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		check("bresp", bresp, er);
	endtask
	task automatic axiRead(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		rready <= 1'b0;
		check("rresp", rresp, er);
	endtask
	task automatic rdCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		axiRead(a, `RESP_OKAY, v);
		check(name, v, exp);
	endtask
	task automatic waitResult(input bit sup);
		do @(negedge mclk); while ((sup ? supplyResultValid : tempResultValid) !== 1'b1);
	endtask

	task automatic testReset;
		rdCheck("ctrl", `REG_CTRL, 32'h0);
		rdCheck("cfg", `REG_CFG, 32'h0);
		rdCheck("minHigh", `REG_MIN_HIGH, 32'hff);
		check("pcmEnable", pcmDoutEnable, 1'b0);
		axiRead(8'h40, `RESP_SLVERR, rd);
		check("unmapped", rd, 32'h0);
		axiWrite(`REG_TEMP_HIGH, 32'h1, `RESP_SLVERR);
		repeat (400) @(posedge mclk);
		check("idleStarts", starts, 0);
	endtask
	task automatic testTempAuto;
		tempVal <= 9'h1a5;
		axiWrite(`REG_CTRL, 32'h1, `RESP_OKAY);
		waitResult(1'b0);
		check("tempResult", tempResult, 9'h1a5);
		rdCheck("tempHigh", `REG_TEMP_HIGH, 32'hd2);
		rdCheck("tempLow", `REG_TEMP_LOW, 32'h1);
		tempVal <= 9'h0c6;
		waitResult(1'b0);
		waitResult(1'b0);
		rdCheck("tempAuto", `REG_TEMP_HIGH, 32'h63);
	endtask
	task automatic testTempManual;
		slow <= 1'b1;
		axiWrite(`REG_CFG, 32'h4, `RESP_OKAY);
		tempVal <= 9'h13b;
		waitResult(1'b0);
		waitResult(1'b0);
		check("tempFeed", tempResult, 9'h13b);
		rdCheck("tempHeld", `REG_TEMP_HIGH, 32'h63);
		axiWrite(`REG_UPDATE, 32'h1, `RESP_OKAY);
		rdCheck("tempUpdate", `REG_TEMP_HIGH, 32'h9d);
		rdCheck("tempUpdLow", `REG_TEMP_LOW, 32'h1);
		slow <= 1'b0;
	endtask
	task automatic testSupply;
		supplyVal <= 9'h151;
		axiWrite(`REG_CFG, 32'h1, `RESP_OKAY);
		do @(negedge mclk); while (!(measStart === 1'b1 && measChannel === `CH_TEMP));
		do @(negedge mclk); while (measStart !== 1'b1);
		check("order", measChannel, `CH_SUPPLY);
		waitResult(1'b1);
		check("supply", supplyResult, 9'h151);
		rdCheck("minFirst", `REG_MIN_HIGH, 32'ha8);
		supplyVal <= 9'h1c0;
		waitResult(1'b1);
		waitResult(1'b1);
		rdCheck("minKept", `REG_MIN_HIGH, 32'ha8);
		rdCheck("minLow", `REG_MIN_LOW, 32'h1);
		rdCheck("minReload", `REG_MIN_HIGH, 32'he0);
		rdCheck("supHigh", `REG_SUPPLY_HIGH, 32'he0);
		axiWrite(`REG_CFG, 32'h9, `RESP_OKAY);
		supplyVal <= 9'h0f0;
		waitResult(1'b1);
		waitResult(1'b1);
		rdCheck("supHeld", `REG_SUPPLY_HIGH, 32'he0);
		axiWrite(`REG_UPDATE, 32'h2, `RESP_OKAY);
		rdCheck("supUpdate", `REG_SUPPLY_HIGH, 32'h78);
	endtask
	task automatic sensePulse(input logic [15:0] c);
		@(posedge mclk);
		currentRaw <= c;
		senseValid <= 1'b1;
		@(posedge mclk);
		senseValid <= 1'b0;
	endtask
	// one frame: collect the first 16 bits, msb first
	task automatic pcmFrame(output logic [15:0] cur);
		repeat (8) @(posedge mclk);
		pcmLrclk <= 1'b1;
		repeat (8) @(posedge mclk);
		for (int i = 15; i >= 0; i--) begin
			cur[i] = pcmDout;
			pcmBclk <= 1'b1;
			repeat (4) @(posedge mclk);
			pcmBclk <= 1'b0;
			repeat (8) @(posedge mclk);
		end
		pcmLrclk <= 1'b0;
	endtask
	task automatic testPcm;
		logic [15:0] v;
		axiWrite(`REG_CTRL, 32'h47, `RESP_OKAY);
		voltageRaw <= 16'h8001;
		sensePulse(16'hb3c5);
		pcmFrame(v);
		check("pcmEnable", pcmDoutEnable, 1'b1);
		check("pcmCurrent", v, 32'hb3c5);
		check("pcmVoltage", pcmDout, 1'b1);
	endtask
	task automatic testSenseFilt;
		logic [15:0] v;
		axiWrite(`REG_CTRL, 32'h40, `RESP_OKAY);
		sensePulse(16'h0400);
		pcmFrame(v);
		check("senseOff", v, 32'h0);
		axiWrite(`REG_CTRL, 32'h57, `RESP_OKAY);
		sensePulse(16'h0000);
		sensePulse(16'h0400);
		sensePulse(16'h0400);
		pcmFrame(v);
		check("dcBlock", v, 32'h03ff);
		axiWrite(`REG_CTRL, 32'h4f, `RESP_OKAY);
		sensePulse(16'h0100);
		pcmFrame(v);
		check("dither", v[15:1], 32'h0080);
	endtask
	task automatic testTempFilt;
		axiWrite(`REG_CFG, 32'h120, `RESP_OKAY);
		waitResult(1'b0);
		tempVal <= 9'h03b;
		waitResult(1'b0);
		check("tempFilter", tempResult, 9'h0bb);
	endtask

	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready, senseValid, slow} = 8'hff;
		{awvalid, wvalid, bready, arvalid, rready, senseValid, slow} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
		{currentRaw, voltageRaw, pcmBclk, pcmLrclk} = 34'h0;
		{tempVal, supplyVal} = 18'h0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		testReset();
		testTempAuto();
		testTempManual();
		testSupply();
		testTempFilt();
		testPcm();
		testSenseFilt();
		summarize();
	end
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
endmodule
